// ==== ppam_pkg.sv ====
// Shared constants and types for the parallel port address pin mux
package ppam_pkg;

    // ==========================================
    // Register map (APB byte addresses)
    localparam logic [11:0] ADDR_BUSCTL = 12'h000;
    localparam logic [11:0] ADDR_MGC1 = 12'h004;
    localparam logic [11:0] ADDR_MGC2 = 12'h008;
    localparam logic [11:0] ADDR_GDIR = 12'h00c;
    localparam logic [11:0] ADDR_GOUT = 12'h010;
    localparam logic [11:0] ADDR_STAT = 12'h014;
    localparam logic [11:0] ADDR_HOST = 12'h018;

    // ==========================================
    // Field positions
    localparam int BIT_HOLDER_EN = 0;
    localparam int BIT_CLK_HZ = 0;
    localparam int POS_GPIO_IN = 0;
    localparam int BIT_MEMIF_SEL = 8;
    localparam int BIT_IN_RESET = 9;
    localparam int BIT_HOLD = 10;
    localparam int BIT_OFF = 11;
    localparam int POS_HOST_ADDR = 16;

    // ==========================================
    // Reset values
    localparam logic [31:0] BUSCTL_RESET = 32'h0000_0001;
    localparam logic [31:0] MGC_RESET = 32'h0000_0000;
    localparam logic [3:0] GDIR_RESET = 4'h0;
    localparam logic [3:0] GOUT_RESET = 4'h0;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

    // ==========================================
    // Pin widths
    localparam int UPPER_W = 4;
    localparam int LOWER_W = 16;
    localparam int CLK_N = 2;

    // ==========================================
    // Pin function state, one-hot
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_HOST = 3'b010,
        ST_MEMIF = 3'b100
    } ppam_state_t;

    // Causes that float the address pins
    typedef struct packed {
        logic in_reset;
        logic hold;
        logic off;
    } ppam_float_t;

endpackage

// ==== ppam_pad_group.sv ====
// One group of three-state address pads with a bus holder
`timescale 1ns/1ps
`default_nettype none

module ppam_pad_group
    import ppam_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Requested drive
    input wire logic [W-1:0] drive_en,
    input wire logic [W-1:0] drive_val,
    input wire logic force_z,
    input wire logic holder_on,
    // Pad side
    output logic [W-1:0] pad_o,
    output logic [W-1:0] pad_oe,
    output logic [W-1:0] keep_en,
    output logic [W-1:0] keep_val
);

    logic [W-1:0] o_q, o_d, oe_q, oe_d, last_q, last_d;

    // ==========================================
    // Drive and holder level
    always_comb begin
        oe_d = force_z ? '0 : drive_en;
        o_d = drive_val;
        // Holder remembers only bits that were really driven
        last_d = (oe_q & o_q) | (~oe_q & last_q);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            o_q <= '0;
            oe_q <= '0;
            last_q <= '0;
        end else begin
            o_q <= o_d;
            oe_q <= oe_d;
            last_q <= last_d;
        end
    end

    assign pad_o = o_q;
    assign pad_oe = oe_q;
    assign keep_en = holder_on ? ~oe_q : '0;
    assign keep_val = last_d;

endmodule
`default_nettype wire

// ==== ppam_boot_latch.sv ====
// Boot-select sampler that reports the release of the device reset pin
`timescale 1ns/1ps
`default_nettype none

module ppam_boot_latch
    import ppam_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pins
    input wire logic reset_pin_n,
    input wire logic boot_select_pin,
    // Result
    output logic release_pulse,
    output logic boot_level
);

    logic sample_q, sample_d, prev_q, prev_d;

    // ==========================================
    // Sample while the pin reset is held
    always_comb begin
        sample_d = reset_pin_n ? sample_q : boot_select_pin;
        prev_d = reset_pin_n;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sample_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sample_q <= sample_d;
            prev_q <= prev_d;
        end
    end

    // Level held on the last cycle of pin reset is the choice
    assign release_pulse = reset_pin_n & ~prev_q;
    assign boot_level = sample_q;

endmodule
`default_nettype wire

// ==== ppam_top.sv ====
// Address pin function mux with bus holders and APB control registers
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Boot-select low gives the four upper pins to GPIO bits, high to memory address bits 21..18.
// - The function is fixed when the reset pin rises and held until the reset pin falls again.
// - In GPIO function the four GPIO bits come out of reset as inputs.
// - In memory function the upper pins float during reset and then drive zero.
// - A floated pin with holders on keeps the level it last drove.
// - Holders are on after reset and software switches them by a control bit.
// - Boot-select low gives the sixteen lower pins to host address, high to memory address 17..2.
// - In host function the sixteen host address pins are inputs after reset.
// - Host function is non-multiplexed with separate 16-bit address and data buses.
// - Each host access cycle moves exactly one 16-bit word.
// - The address pins float while hold is requested.
// - In hold each memory clock runs if its tristate bit is 0 and floats if 1.
// - The pins float in off mode: test reset 0, emulation zero 1, emulation one 0.
// - All address pins float while the reset pin is low.
module ppam_top
    import ppam_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device control pins
    input wire logic reset_pin_n,
    input wire logic boot_select_pin,
    input wire logic hold_pin_n,
    input wire logic test_reset_n,
    input wire logic emulation_pin_zero,
    input wire logic emulation_one_off_pin,
    // Upper address pins
    input wire logic [UPPER_W-1:0] addr_up_i,
    output logic [UPPER_W-1:0] addr_up_o,
    output logic [UPPER_W-1:0] addr_up_oe,
    output logic [UPPER_W-1:0] addr_up_keep_en,
    output logic [UPPER_W-1:0] addr_up_keep_val,
    // Lower address pins
    input wire logic [LOWER_W-1:0] addr_lo_i,
    output logic [LOWER_W-1:0] addr_lo_o,
    output logic [LOWER_W-1:0] addr_lo_oe,
    output logic [LOWER_W-1:0] addr_lo_keep_en,
    output logic [LOWER_W-1:0] addr_lo_keep_val,
    // Memory clocks
    input wire logic [CLK_N-1:0] memclk_src,
    output logic [CLK_N-1:0] memory_clock_output,
    output logic [CLK_N-1:0] memory_clock_oe,
    // Memory controller side
    input wire logic [UPPER_W-1:0] memif_addr_upper,
    input wire logic [LOWER_W-1:0] memif_addr_lower,
    // Host port side
    input wire logic host_strobe,
    input wire logic [LOWER_W-1:0] host_port_data,
    output logic [LOWER_W-1:0] host_port_address,
    output logic [LOWER_W-1:0] host_word,
    output logic host_word_valid,
    // Function status
    output logic func_memif,
    output logic func_host
);

    // ==========================================
    // Function selection
    ppam_state_t st_q, st_d;
    logic release_pulse, boot_level;

    ppam_boot_latch u_latch (
        .clk(clk),
        .reset(reset),
        .reset_pin_n(reset_pin_n),
        .boot_select_pin(boot_select_pin),
        .release_pulse(release_pulse),
        .boot_level(boot_level)
    );

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RESET: begin
                if (release_pulse) begin
                    st_d = boot_level ? ST_MEMIF : ST_HOST;
                end
            end
            ST_HOST, ST_MEMIF: begin
                if (!reset_pin_n) begin
                    st_d = ST_RESET;
                end
            end
            default: st_d = ST_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign func_memif = (st_q == ST_MEMIF);
    assign func_host = (st_q == ST_HOST);

    // ==========================================
    // Float causes
    ppam_float_t flt;
    logic force_z;

    always_comb begin
        flt.in_reset = !reset_pin_n || (st_q == ST_RESET);
        flt.hold = !hold_pin_n;
        flt.off = !test_reset_n && emulation_pin_zero
            && !emulation_one_off_pin;
        force_z = flt.in_reset | flt.hold | flt.off;
    end

    // ==========================================
    // Registers
    logic [31:0] busctl_q, busctl_d, mgc1_q, mgc1_d, mgc2_q, mgc2_d;
    logic [UPPER_W-1:0] gdir_q, gdir_d, gout_q, gout_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic wr_en, setup;
    logic [31:0] status;

    assign wr_en = psel && penable && pwrite;
    assign setup = psel && !penable;

    always_comb begin
        status = '0;
        status[POS_GPIO_IN +: UPPER_W] = addr_up_i;
        status[BIT_MEMIF_SEL] = func_memif;
        status[BIT_IN_RESET] = flt.in_reset;
        status[BIT_HOLD] = flt.hold;
        status[BIT_OFF] = flt.off;
    end

    always_comb begin
        busctl_d = busctl_q;
        mgc1_d = mgc1_q;
        mgc2_d = mgc2_q;
        gdir_d = gdir_q;
        gout_d = gout_q;
        rdata_d = rdata_q;
        err_d = err_q;
        if (wr_en) begin
            unique case (paddr)
                ADDR_BUSCTL: busctl_d = {31'h0, pwdata[BIT_HOLDER_EN]};
                ADDR_MGC1: mgc1_d = {31'h0, pwdata[BIT_CLK_HZ]};
                ADDR_MGC2: mgc2_d = {31'h0, pwdata[BIT_CLK_HZ]};
                ADDR_GDIR: gdir_d = pwdata[UPPER_W-1:0];
                ADDR_GOUT: gout_d = pwdata[UPPER_W-1:0];
                default: ;
            endcase
        end
        // Directions return to input whenever the pin reset is seen
        if (flt.in_reset) begin
            gdir_d = GDIR_RESET;
        end
        if (setup) begin
            err_d = 1'b0;
            unique case (paddr)
                ADDR_BUSCTL: rdata_d = busctl_q;
                ADDR_MGC1: rdata_d = mgc1_q;
                ADDR_MGC2: rdata_d = mgc2_q;
                ADDR_GDIR: rdata_d = {28'h0, gdir_q};
                ADDR_GOUT: rdata_d = {28'h0, gout_q};
                ADDR_STAT: begin
                    rdata_d = status;
                    err_d = pwrite;
                end
                ADDR_HOST: begin
                    rdata_d = {host_port_address, host_word};
                    err_d = pwrite;
                end
                default: begin
                    rdata_d = RDATA_IDLE;
                    err_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busctl_q <= BUSCTL_RESET;
            mgc1_q <= MGC_RESET;
            mgc2_q <= MGC_RESET;
            gdir_q <= GDIR_RESET;
            gout_q <= GOUT_RESET;
            rdata_q <= RDATA_IDLE;
            err_q <= 1'b0;
        end else begin
            busctl_q <= busctl_d;
            mgc1_q <= mgc1_d;
            mgc2_q <= mgc2_d;
            gdir_q <= gdir_d;
            gout_q <= gout_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // Answer is prepared in setup so access needs no wait state
    assign pready = psel && penable;
    assign prdata = rdata_q;
    assign pslverr = pready && err_q;

    // ==========================================
    // Address sources and pads
    logic [UPPER_W-1:0] up_addr_q, up_addr_d, up_en, up_val;
    logic [LOWER_W-1:0] lo_addr_q, lo_addr_d, lo_en;

    always_comb begin
        // Held at zero outside memory function so drive starts at 0
        up_addr_d = func_memif ? memif_addr_upper : '0;
        lo_addr_d = func_memif ? memif_addr_lower : '0;
        up_en = func_memif ? '1 : (func_host ? gdir_q : '0);
        up_val = func_memif ? up_addr_q : gout_q;
        lo_en = func_memif ? '1 : '0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            up_addr_q <= '0;
            lo_addr_q <= '0;
        end else begin
            up_addr_q <= up_addr_d;
            lo_addr_q <= lo_addr_d;
        end
    end

    ppam_pad_group #(.W(UPPER_W)) u_pad_up (
        .clk(clk),
        .reset(reset),
        .drive_en(up_en),
        .drive_val(up_val),
        .force_z(force_z),
        .holder_on(busctl_q[BIT_HOLDER_EN]),
        .pad_o(addr_up_o),
        .pad_oe(addr_up_oe),
        .keep_en(addr_up_keep_en),
        .keep_val(addr_up_keep_val)
    );

    ppam_pad_group #(.W(LOWER_W)) u_pad_lo (
        .clk(clk),
        .reset(reset),
        .drive_en(lo_en),
        .drive_val(lo_addr_q),
        .force_z(force_z),
        .holder_on(busctl_q[BIT_HOLDER_EN]),
        .pad_o(addr_lo_o),
        .pad_oe(addr_lo_oe),
        .keep_en(addr_lo_keep_en),
        .keep_val(addr_lo_keep_val)
    );

    // ==========================================
    // Memory clocks in hold
    logic [CLK_N-1:0] clk_hz;

    always_comb begin
        clk_hz = {mgc2_q[BIT_CLK_HZ], mgc1_q[BIT_CLK_HZ]};
        memory_clock_oe = flt.hold ? ~clk_hz : '1;
        memory_clock_output = memclk_src;
    end

    // ==========================================
    // Host port capture, one word per strobe
    logic strobe_q, strobe_d, hvalid_q, hvalid_d, take;
    logic [LOWER_W-1:0] haddr_q, haddr_d, hword_q, hword_d;

    always_comb begin
        take = host_strobe && !strobe_q && func_host && !force_z;
        strobe_d = host_strobe;
        hvalid_d = take;
        haddr_d = take ? addr_lo_i : haddr_q;
        hword_d = take ? host_port_data : hword_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            strobe_q <= 1'b0;
            hvalid_q <= 1'b0;
            haddr_q <= '0;
            hword_q <= '0;
        end else begin
            strobe_q <= strobe_d;
            hvalid_q <= hvalid_d;
            haddr_q <= haddr_d;
            hword_q <= hword_d;
        end
    end

    assign host_port_address = haddr_q;
    assign host_word = hword_q;
    assign host_word_valid = hvalid_q;

    // ==========================================
    // Checks
    a_reset_pins_float: assert property (@(posedge clk) disable iff (reset)
        !reset_pin_n |=> (addr_up_oe == '0) && (addr_lo_oe == '0))
        else $error("address pin driven during pin reset");
    a_hold_pins_float: assert property (@(posedge clk) disable iff (reset)
        !hold_pin_n |=> (addr_up_oe == '0) && (addr_lo_oe == '0))
        else $error("address pin driven during hold");
    a_off_pins_float: assert property (@(posedge clk) disable iff (reset)
        (!test_reset_n && emulation_pin_zero && !emulation_one_off_pin)
        |=> (addr_up_oe == '0) && (addr_lo_oe == '0))
        else $error("address pin driven in off mode");
    a_memclk_hold_hz: assert property (@(posedge clk) disable iff (reset)
        !hold_pin_n |-> (memory_clock_oe == ~{mgc2_q[0], mgc1_q[0]}))
        else $error("memory clock enable wrong in hold");
    a_boot_choice_map: assert property (@(posedge clk) disable iff (reset)
        (st_q == ST_RESET && release_pulse)
        |=> (func_memif == $past(boot_level)) && (func_host != func_memif))
        else $error("function does not follow boot select");
    a_choice_stays_fixed: assert property (@(posedge clk) disable iff (reset)
        (func_memif && reset_pin_n) |=> func_memif || !$past(reset_pin_n))
        else $error("function changed without pin reset");
    a_gpio_start_input: assert property (@(posedge clk) disable iff (reset)
        $rose(func_host) |-> (gdir_q == '0) ##1 (addr_up_oe == '0))
        else $error("gpio not input after reset");
    a_memif_drive_zero: assert property (@(posedge clk) disable iff (reset)
        ($rose(func_memif) && !force_z) ##1 !force_z
        |=> (addr_up_oe == '1) && (addr_up_o == '0) && (addr_lo_o == '0))
        else $error("memory address not zero after reset");
    a_host_pins_input: assert property (@(posedge clk) disable iff (reset)
        func_host |=> (addr_lo_oe == '0))
        else $error("host address pin driven");
    a_holder_keeps_level: assert property (@(posedge clk) disable iff (reset)
        (addr_up_oe[0] ##1 !addr_up_oe[0])
        |-> addr_up_keep_val[0] == $past(addr_up_o[0]))
        else $error("holder lost the last driven level");
    a_holder_default_on: assert property (@(posedge clk)
        $fell(reset) |-> busctl_q[BIT_HOLDER_EN])
        else $error("holders not enabled after reset");
    a_host_one_word: assert property (@(posedge clk) disable iff (reset)
        take |=> host_word_valid && (host_word == $past(host_port_data))
        ##1 !host_word_valid)
        else $error("host word not captured once");

endmodule
`default_nettype wire

// ==== ppam_host_model.sv ====
// Host processor model driving the host address and data pins
`timescale 1ns/1ps
`default_nettype none

module ppam_host_model
    import ppam_pkg::*;
(
    // Clock
    input wire logic clk,
    // Device pin side
    input wire logic [LOWER_W-1:0] addr_lo_o,
    input wire logic [LOWER_W-1:0] addr_lo_oe,
    input wire logic [LOWER_W-1:0] addr_lo_keep_en,
    input wire logic [LOWER_W-1:0] addr_lo_keep_val,
    // Host pins
    output logic [LOWER_W-1:0] addr_lo_i,
    output logic [LOWER_W-1:0] host_port_data,
    output var logic host_strobe
);
    logic [LOWER_W-1:0] ha_q = '0;
    logic drv_q = 1'b0;
    logic [LOWER_W-1:0] ext;

    initial begin
        host_port_data = '0;
        host_strobe = 1'b0;
    end

    // ==========================================
    // Pin level
    // Device drive wins; a released line shows the holder level, or with holders off the inverse of the last
    // address so a stale value can never pass for a capture
    assign ext = drv_q ? ha_q
        : ((addr_lo_keep_en & addr_lo_keep_val) | (~addr_lo_keep_en & ~ha_q));
    assign addr_lo_i = (addr_lo_oe & addr_lo_o) | (~addr_lo_oe & ext);

    // ==========================================
    // One access: address and data set up, one strobe, one word
    task automatic access(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        ha_q <= a;
        host_port_data <= d;
        drv_q <= 1'b1;
        @(posedge clk);
        host_strobe <= 1'b1;
        repeat (2) @(posedge clk);
        host_strobe <= 1'b0;
        @(posedge clk);
        drv_q <= 1'b0;
        host_port_data <= ~d;
    endtask
endmodule

`default_nettype wire

// ==== ppam_top_test.sv ====
// Self-checking bench for the address pin function mux
`timescale 1ns/1ps
`default_nettype none

module ppam_top_test;
    import ppam_pkg::*;

    logic clk = 1'b0;
    logic reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic reset_pin_n, boot_select_pin, hold_pin_n, test_reset_n;
    logic emulation_pin_zero, emulation_one_off_pin;
    logic [3:0] gpio_ext, addr_up_i, addr_up_o, addr_up_oe;
    logic [3:0] up_keep_en, up_keep_val, memif_addr_upper;
    logic [15:0] addr_lo_i, addr_lo_o, addr_lo_oe, lo_keep_en, lo_keep_val;
    logic [15:0] memif_addr_lower, host_port_data, host_port_address;
    logic [15:0] host_word;
    logic [1:0] memclk_src, memory_clock_output, memory_clock_oe;
    logic host_strobe, host_word_valid, func_memif, func_host;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_valid = 0;

    always #2.5 clk = ~clk;
    assign memclk_src = {clk, ~clk};
    assign addr_up_i = (addr_up_oe & addr_up_o) | (~addr_up_oe & gpio_ext);

    ppam_top u_ppam_top (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .boot_select_pin(boot_select_pin), .hold_pin_n(hold_pin_n),
        .test_reset_n(test_reset_n), .emulation_pin_zero(emulation_pin_zero),
        .emulation_one_off_pin(emulation_one_off_pin), .addr_up_i(addr_up_i),
        .addr_up_o(addr_up_o), .addr_up_oe(addr_up_oe),
        .addr_up_keep_en(up_keep_en), .addr_up_keep_val(up_keep_val),
        .addr_lo_i(addr_lo_i), .addr_lo_o(addr_lo_o), .addr_lo_oe(addr_lo_oe),
        .addr_lo_keep_en(lo_keep_en), .addr_lo_keep_val(lo_keep_val),
        .memclk_src(memclk_src), .memory_clock_output(memory_clock_output),
        .memory_clock_oe(memory_clock_oe), .memif_addr_upper(memif_addr_upper),
        .memif_addr_lower(memif_addr_lower), .host_strobe(host_strobe),
        .host_port_data(host_port_data), .host_port_address(host_port_address),
        .host_word(host_word), .host_word_valid(host_word_valid),
        .func_memif(func_memif), .func_host(func_host)
    );

    ppam_host_model u_ppam_host_model (
        .clk(clk), .addr_lo_o(addr_lo_o), .addr_lo_oe(addr_lo_oe),
        .addr_lo_keep_en(lo_keep_en), .addr_lo_keep_val(lo_keep_val),
        .addr_lo_i(addr_lo_i), .host_port_data(host_port_data),
        .host_strobe(host_strobe)
    );

    // ==========================================
    // Helpers
    task finish_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Zero wait states today, but the master still waits on pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk(err, e);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        chk(err, e);
    endtask

    task pin_reset(input logic boot);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        boot_select_pin <= boot;
        wt(2);
        chk(addr_up_oe, 4'h0);
        chk(addr_lo_oe, 16'h0);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        wt(3);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (host_word_valid === 1'b1)
            n_valid++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        reset_pin_n = 1'b0;
        boot_select_pin = 1'b1;
        hold_pin_n = 1'b1;
        test_reset_n = 1'b1;
        emulation_pin_zero = 1'b0;
        emulation_one_off_pin = 1'b1;
        gpio_ext = 4'h0;
        memif_addr_upper = 4'h0;
        memif_addr_lower = 16'h0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd_chk(ADDR_BUSCTL, BUSCTL_RESET, 1'b0);
        rd_chk(ADDR_MGC1, MGC_RESET, 1'b0);
        rd_chk(ADDR_MGC2, MGC_RESET, 1'b0);
        rd_chk(ADDR_GDIR, 32'h0, 1'b0);
        rd_chk(12'h040, RDATA_IDLE, 1'b1);
        wr(ADDR_STAT, 32'hffff_ffff, 1'b1);
        rd_chk(ADDR_STAT, 32'h200, 1'b0);
        chk(addr_up_oe, 4'h0);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        wt(3);
        chk(func_memif, 1'b1);
        chk(addr_up_oe, 4'hf);
        chk(addr_up_o, 4'h0);
        chk(addr_lo_oe, 16'hffff);
        @(posedge clk);
        boot_select_pin <= 1'b0;
        memif_addr_upper <= 4'hc;
        memif_addr_lower <= 16'h5a3c;
        wt(3);
        chk(func_memif, 1'b1);
        chk(addr_up_o, 4'hc);
        chk(addr_lo_o, 16'h5a3c);
        rd_chk(ADDR_STAT, 32'h10c, 1'b0);
        // Hold with clock 0 set to float
        wr(ADDR_MGC1, 32'h1, 1'b0);
        @(posedge clk);
        hold_pin_n <= 1'b0;
        wt(2);
        chk(addr_up_oe, 4'h0);
        chk(addr_lo_oe, 16'h0);
        chk(up_keep_en, 4'hf);
        chk(up_keep_val, 4'hc);
        chk(lo_keep_val, 16'h5a3c);
        chk(memory_clock_oe, 2'b10);
        chk(memory_clock_output, memclk_src);
        wr(ADDR_BUSCTL, 32'h0, 1'b0);
        wt(1);
        chk(lo_keep_en, 16'h0);
        rd_chk(ADDR_BUSCTL, 32'h0, 1'b0);
        wr(ADDR_BUSCTL, 32'h1, 1'b0);
        @(posedge clk);
        hold_pin_n <= 1'b1;
        wt(3);
        chk(addr_up_oe, 4'hf);
        chk(memory_clock_oe, 2'b11);
        // Off mode, then a near miss that must not float
        @(posedge clk);
        test_reset_n <= 1'b0;
        emulation_pin_zero <= 1'b1;
        emulation_one_off_pin <= 1'b0;
        wt(2);
        chk(addr_up_oe, 4'h0);
        chk(addr_lo_oe, 16'h0);
        rd_chk(ADDR_STAT, 32'h900, 1'b0);
        @(posedge clk);
        emulation_pin_zero <= 1'b0;
        wt(3);
        chk(addr_lo_oe, 16'hffff);
        @(posedge clk);
        test_reset_n <= 1'b1;
        emulation_one_off_pin <= 1'b1;
        // Host and GPIO function
        pin_reset(1'b0);
        chk(func_host, 1'b1);
        chk(addr_up_oe, 4'h0);
        chk(addr_lo_oe, 16'h0);
        @(posedge clk);
        gpio_ext <= 4'ha;
        wt(1);
        rd_chk(ADDR_STAT, 32'ha, 1'b0);
        wr(ADDR_GDIR, 32'h3, 1'b0);
        wr(ADDR_GOUT, 32'h5, 1'b0);
        wt(2);
        chk(addr_up_oe, 4'h3);
        chk(addr_up_o & 4'h3, 4'h1);
        rd_chk(ADDR_STAT, 32'h9, 1'b0);
        u_ppam_host_model.access(16'h1234, 16'hbeef);
        wt(1);
        chk(host_port_address, 16'h1234);
        chk(host_word, 16'hbeef);
        chk(n_valid, 1);
        rd_chk(ADDR_HOST, 32'h1234_beef, 1'b0);
        u_ppam_host_model.access(16'hffff, 16'h0001);
        wt(1);
        chk(host_word, 16'h0001);
        chk(n_valid, 2);
        // A strobe while held floated is ignored
        @(posedge clk);
        hold_pin_n <= 1'b0;
        u_ppam_host_model.access(16'h0f0f, 16'h7777);
        wt(1);
        chk(n_valid, 2);
        // Second clock told to float too, still in hold
        wr(ADDR_MGC2, 32'h1, 1'b0);
        wt(1);
        chk(memory_clock_oe, 2'b00);
        finish_test;
    end
endmodule

`default_nettype wire
